/* rtl/slcd_pkg.sv */
// constants and types shared by the segment panel control block
package slcd_pkg;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned GROUPS        = 3;   // segment byte groups per common line
  localparam int unsigned LINES         = 4;   // common lines
  localparam int unsigned PIXEL_REGS    = GROUPS * LINES;
  // register offsets
  localparam logic [4:0] OFS_CONTROL    = 5'h00;
  localparam logic [4:0] OFS_PRESCALE   = 5'h01;
  localparam logic [4:0] OFS_STATUS     = 5'h02;
  localparam logic [4:0] OFS_PINSEL0    = 5'h04;
  localparam logic [4:0] OFS_PIXEL0     = 5'h08;
  // control register fields
  localparam int unsigned CTL_ON_BIT    = 7;
  localparam int unsigned CTL_SLEEP_BIT = 6;
  // prescale register fields
  localparam int unsigned PS_TYPEB_BIT  = 7;
  localparam int unsigned PS_DIV_W      = 4;
  // status register fields
  localparam int unsigned ST_ACTIVE_BIT = 0;
  localparam int unsigned ST_SLEEP_BIT  = 1;
  localparam int unsigned ST_PHASE_LSB  = 2;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [1:0] LINE_ZERO      = 2'h0;
  typedef enum logic [2:0] {
    SLCD_IDLE   = 3'b001,
    SLCD_DRIVE  = 3'b010,
    SLCD_HALT   = 3'b100
  } slcd_state_t;
endpackage

/* rtl/slcd_tick_if.sv */
// prescaler tick link between the top and the divider
`timescale 1ns/100ps
`default_nettype none
interface slcd_tick_if;
  logic       run;
  logic [3:0] div;
  logic       tick;
  modport top (output run, output div, input tick);
  modport divider (input run, input div, output tick);
endinterface
`default_nettype wire

/* rtl/slcd_divider.sv */
// programmable prescaler for the panel clock source
`timescale 1ns/100ps
`default_nettype none
module slcd_divider (
  input  wire logic     clock_i,
  input  wire logic     sys_rst_i,
  slcd_tick_if.divider  tk
);
  logic [3:0] cnt_reg;
  logic       tick_reg;
  // counts up from zero to div, one tick every div+1 cycles while running
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else if (!tk.run) begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= tk.div) begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end
  assign tk.tick = tick_reg;
endmodule
`default_nettype wire

/* rtl/slcd_pixel_mux.sv */
// picks one common line's column pixels out of the pixel store
`timescale 1ns/100ps
`default_nettype none
module slcd_pixel_mux #(
  parameter int unsigned GROUPS = 3,
  parameter int unsigned LINES  = 4
) (
  input  wire logic [LINES*GROUPS*8-1:0] pixels_i,
  input  wire logic [1:0]                line_i,
  output logic      [GROUPS*8-1:0]       columns_o
);
  // register index = 3 * line + group
  always_comb begin
    columns_o = '0;
    for (int l = 0; l < LINES; l++) begin
      if (line_i == l[1:0]) begin
        columns_o = pixels_i[l*GROUPS*8 +: GROUPS*8];
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/slcd_control.sv */
// segment panel control, pin selection and pixel storage
//
// Contract
// - prescale register sets the panel clock division and picks waveform type A or B
// - three pin select bytes decide which of 24 pins drive column lines
// - pixel bit set means dark; register index is three times line plus group
// - module-on bit starts or stops panel drive
// - with sleep-stop clear, drive keeps running through processor sleep
`timescale 1ns/100ps
`default_nettype none
module slcd_control #(
  parameter int unsigned GROUPS = 3,
  parameter int unsigned LINES  = 4
) (
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire logic [4:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [7:0]          rdata_o,
  input  wire logic                cpu_sleep_i,
  output logic                     panel_active_o,
  output logic                     wave_type_b_o,
  output logic      [1:0]          common_line_o,
  output logic      [GROUPS*8-1:0] pin_drive_select_o,
  output logic      [GROUPS*8-1:0] column_line_o
);
  logic [7:0]                panel_control_reg;
  logic [7:0]                phase_prescale_reg;
  logic [7:0]                pin_select_reg [GROUPS];
  logic [7:0]                pixel_word_reg [GROUPS*LINES];
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic [1:0]                line_reg;
  logic                      active_reg;
  logic                      type_b_reg;
  logic [GROUPS*8-1:0]       pinsel_reg;
  logic [GROUPS*8-1:0]       column_reg;
  logic [LINES*GROUPS*8-1:0] pixels_flat;
  logic [GROUPS*8-1:0]       columns_sel;
  logic                      panel_module_on;
  logic                      sleep_stop_bit;
  slcd_pkg::slcd_state_t     state_reg;
  slcd_pkg::slcd_state_t     state_next;
  slcd_tick_if               tk ();

  assign panel_module_on = panel_control_reg[slcd_pkg::CTL_ON_BIT];
  assign sleep_stop_bit  = panel_control_reg[slcd_pkg::CTL_SLEEP_BIT];

  // control and prescale register writes
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      panel_control_reg  <= slcd_pkg::RESET_BYTE;
      phase_prescale_reg <= slcd_pkg::RESET_BYTE;
    end else if (wr_i) begin
      if (addr_i == slcd_pkg::OFS_CONTROL) begin
        panel_control_reg <= wdata_i;
      end
      if (addr_i == slcd_pkg::OFS_PRESCALE) begin
        phase_prescale_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int g = 0; g < GROUPS; g++) begin
        pin_select_reg[g] <= slcd_pkg::RESET_BYTE;
      end
    end else if (wr_i) begin
      for (int g = 0; g < GROUPS; g++) begin
        if (addr_i == slcd_pkg::OFS_PINSEL0 + 5'(g)) begin
          pin_select_reg[g] <= wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < GROUPS*LINES; i++) begin
        pixel_word_reg[i] <= slcd_pkg::RESET_BYTE;
      end
    end else if (wr_i) begin
      for (int i = 0; i < GROUPS*LINES; i++) begin
        if (addr_i == slcd_pkg::OFS_PIXEL0 + 5'(i)) begin
          pixel_word_reg[i] <= wdata_i;
        end
      end
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_next = slcd_pkg::RESET_BYTE;
    if (addr_i == slcd_pkg::OFS_CONTROL) begin
      rdata_next = panel_control_reg;
    end else if (addr_i == slcd_pkg::OFS_PRESCALE) begin
      rdata_next = phase_prescale_reg;
    end else if (addr_i == slcd_pkg::OFS_STATUS) begin
      rdata_next[slcd_pkg::ST_ACTIVE_BIT]                  = active_reg;
      rdata_next[slcd_pkg::ST_SLEEP_BIT]                   = state_reg == slcd_pkg::SLCD_HALT;
      rdata_next[slcd_pkg::ST_PHASE_LSB +: 2]              = line_reg;
    end
    for (int g = 0; g < GROUPS; g++) begin
      if (addr_i == slcd_pkg::OFS_PINSEL0 + 5'(g)) begin
        rdata_next = pin_select_reg[g];
      end
    end
    for (int i = 0; i < GROUPS*LINES; i++) begin
      if (addr_i == slcd_pkg::OFS_PIXEL0 + 5'(i)) begin
        rdata_next = pixel_word_reg[i];
      end
    end
    if (!rd_i) begin
      rdata_next = slcd_pkg::RESET_BYTE;
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= slcd_pkg::RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // drive state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      slcd_pkg::SLCD_IDLE: begin
        if (panel_module_on) begin
          state_next = (cpu_sleep_i && sleep_stop_bit) ? slcd_pkg::SLCD_HALT
                                                       : slcd_pkg::SLCD_DRIVE;
        end
      end
      slcd_pkg::SLCD_DRIVE: begin
        if (!panel_module_on) begin
          state_next = slcd_pkg::SLCD_IDLE;
        end else if (cpu_sleep_i && sleep_stop_bit) begin
          state_next = slcd_pkg::SLCD_HALT;
        end
      end
      slcd_pkg::SLCD_HALT: begin
        if (!panel_module_on) begin
          state_next = slcd_pkg::SLCD_IDLE;
        end else if (!(cpu_sleep_i && sleep_stop_bit)) begin
          state_next = slcd_pkg::SLCD_DRIVE;
        end
      end
      default: begin
        state_next = slcd_pkg::SLCD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= slcd_pkg::SLCD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tk.run = state_reg == slcd_pkg::SLCD_DRIVE;
  assign tk.div = phase_prescale_reg[slcd_pkg::PS_DIV_W-1:0];

  slcd_divider u_divider (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .tk        (tk)
  );

  // common line stepping on each prescaler tick
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_reg <= slcd_pkg::LINE_ZERO;
    end else if (state_reg == slcd_pkg::SLCD_IDLE) begin
      line_reg <= slcd_pkg::LINE_ZERO;
    end else if (tk.tick) begin
      line_reg <= line_reg + 2'h1;
    end
  end

  // flatten pixel store for the selector
  always_comb begin
    for (int i = 0; i < GROUPS*LINES; i++) begin
      pixels_flat[i*8 +: 8] = pixel_word_reg[i];
    end
  end

  slcd_pixel_mux #(
    .GROUPS (GROUPS),
    .LINES  (LINES)
  ) u_mux (
    .pixels_i  (pixels_flat),
    .line_i    (line_reg),
    .columns_o (columns_sel)
  );

  // panel outputs, columns blank unless driving
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_reg <= 1'b0;
      type_b_reg <= 1'b0;
      pinsel_reg <= '0;
      column_reg <= '0;
    end else begin
      active_reg <= state_reg == slcd_pkg::SLCD_DRIVE;
      type_b_reg <= phase_prescale_reg[slcd_pkg::PS_TYPEB_BIT];
      for (int g = 0; g < GROUPS; g++) begin
        pinsel_reg[g*8 +: 8] <= pin_select_reg[g];
        column_reg[g*8 +: 8] <= (state_reg == slcd_pkg::SLCD_DRIVE)
                                ? (columns_sel[g*8 +: 8] & pin_select_reg[g]) : 8'h00;
      end
    end
  end

  assign rdata_o            = rdata_reg;
  assign panel_active_o     = active_reg;
  assign wave_type_b_o      = type_b_reg;
  assign common_line_o      = line_reg;
  assign pin_drive_select_o = pinsel_reg;
  assign column_line_o      = column_reg;
endmodule
`default_nettype wire

/* verif/slcd_control_properties.sv */
// concurrent checks on the segment panel control ports
`timescale 1ns/100ps
`default_nettype none
module slcd_control_properties #(
  parameter int unsigned GROUPS = 3,
  parameter int unsigned LINES  = 4
) (
  input wire logic                clock_i,
  input wire logic                sys_rst_i,
  input wire logic [4:0]          addr_i,
  input wire logic [7:0]          wdata_i,
  input wire logic                wr_i,
  input wire logic                cpu_sleep_i,
  input wire logic                panel_active_o,
  input wire logic                wave_type_b_o,
  input wire logic [GROUPS*8-1:0] pin_drive_select_o,
  input wire logic [GROUPS*8-1:0] column_line_o
);
  logic on_reg;
  logic stop_reg;
  logic ctl_wr;
  // control write decode
  assign ctl_wr = wr_i && addr_i == slcd_pkg::OFS_CONTROL;
  // shadow of the on and sleep-stop bits
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      on_reg   <= 1'b0;
      stop_reg <= 1'b0;
    end else if (ctl_wr) begin
      on_reg   <= wdata_i[slcd_pkg::CTL_ON_BIT];
      stop_reg <= wdata_i[slcd_pkg::CTL_SLEEP_BIT];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_wave_type: assert property (
    wr_i && addr_i == slcd_pkg::OFS_PRESCALE |->
    ##2 wave_type_b_o == $past(wdata_i[slcd_pkg::PS_TYPEB_BIT], 2))
    else $error("wave type does not follow prescale write");
  a_pin_select: assert property (
    wr_i && addr_i == slcd_pkg::OFS_PINSEL0 |->
    ##2 pin_drive_select_o[7:0] == $past(wdata_i, 2))
    else $error("pin select low byte not copied");
  a_col_masked: assert property (
    $stable(pin_drive_select_o) [*3] |-> (column_line_o & ~pin_drive_select_o) == '0)
    else $error("column drives an unselected pin");
  a_dark_idle: assert property (
    !panel_active_o [*3] |-> column_line_o == '0)
    else $error("columns driven while idle");
  a_off_stops: assert property (
    ctl_wr && !wdata_i[slcd_pkg::CTL_ON_BIT] |-> ##3 !panel_active_o)
    else $error("drive still active after off");
  a_on_runs: assert property (
    (on_reg && !cpu_sleep_i) [*4] |-> panel_active_o)
    else $error("drive not running while awake and on");
  a_sleep_keeps: assert property (
    (on_reg && !stop_reg) [*4] |-> panel_active_o)
    else $error("drive stopped with sleep-stop clear");
  a_sleep_halts: assert property (
    (stop_reg && cpu_sleep_i) [*4] |-> !panel_active_o)
    else $error("drive running in sleep with sleep-stop set");
endmodule
bind slcd_control slcd_control_properties #(.GROUPS(GROUPS), .LINES(LINES))
  slcd_control_properties_i (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .cpu_sleep_i,
  .panel_active_o, .wave_type_b_o, .pin_drive_select_o, .column_line_o);
`default_nettype wire

/* verif/slcd_panel_model.sv */
// panel model: records the column pattern of each common line and the cycles between the last two line steps
`timescale 1ns/100ps
`default_nettype none
module slcd_panel_model (
  input  wire logic        clock_i,
  input  wire logic        active_i,
  input  wire logic [1:0]  line_i,
  input  wire logic [23:0] cols_i,
  output logic      [95:0] seen_o,
  output logic      [7:0]  period_o
);
  logic [1:0] prev_line;
  logic [7:0] cnt;
  // latch a line's pattern once the common line has settled
  always_ff @(posedge clock_i) begin
    prev_line <= line_i;
    if (active_i && line_i == prev_line) begin
      seen_o[24*line_i +: 24] <= cols_i;
    end
  end
  // cycles between common line steps
  always_ff @(posedge clock_i) begin
    if (line_i != prev_line) begin
      period_o <= cnt + 8'h01;
      cnt      <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* verif/slcd_control_tb.sv */
// self-checking bench for the segment panel control block
`timescale 1ns/100ps
`default_nettype none
module slcd_control_tb;
  logic        clock_i     = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [4:0]  addr_i      = 5'h00;
  logic [7:0]  wdata_i     = 8'h00;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic        cpu_sleep_i = 1'b0;
  logic [7:0]  rdata_o;
  logic        panel_active_o;
  logic        wave_type_b_o;
  logic [1:0]  common_line_o;
  logic [23:0] pin_drive_select_o;
  logic [23:0] column_line_o;
  logic [95:0] seen;
  logic [7:0]  period;
  int          error_cnt   = 0;
  int          cmp_count   = 0;
  slcd_control slcd_control_i (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .cpu_sleep_i, .panel_active_o, .wave_type_b_o, .common_line_o,
    .pin_drive_select_o, .column_line_o);
  slcd_panel_model slcd_panel_model_i (.clock_i, .active_i(panel_active_o),
    .line_i(common_line_o), .cols_i(column_line_o), .seen_o(seen), .period_o(period));
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  // compare and count
  task automatic chk(input string what, input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  function automatic logic [7:0] pv(input int i);
    return 8'h5a ^ 8'(19 * i);
  endfunction
  // reset values, readback, unmapped place
  task automatic t_regs();
    logic [7:0] d;
    logic [4:0] a;
    for (int i = 0; i < 15; i++) begin
      a = (i < 3) ? slcd_pkg::OFS_PINSEL0 + 5'(i) : slcd_pkg::OFS_PIXEL0 + 5'(i - 3);
      rd(a, d);
      chk("reset value", 24'(d), 24'h000000);
      wr(a, pv(i));
      rd(a, d);
      chk("readback", 24'(d), 24'(pv(i)));
    end
    wr(5'h03, 8'hff);
    rd(5'h03, d);
    chk("unmapped", 24'(d), 24'h000000);
    wr(slcd_pkg::OFS_PRESCALE, 8'h83);
    rd(slcd_pkg::OFS_PRESCALE, d);
    chk("prescale", 24'(d), 24'h000083);
    chk("type b", 24'(wave_type_b_o), 24'h000001);
    $display("t_regs done");
  endtask
  // masked pixels per common line and step time
  task automatic t_drive();
    logic [23:0] mask;
    mask = 24'h3cf00f;
    wr(slcd_pkg::OFS_PINSEL0, mask[7:0]);
    wr(slcd_pkg::OFS_PINSEL0 + 5'h01, mask[15:8]);
    wr(slcd_pkg::OFS_PINSEL0 + 5'h02, mask[23:16]);
    for (int i = 0; i < 12; i++)
      wr(slcd_pkg::OFS_PIXEL0 + 5'(i), pv(i + 7));
    wr(slcd_pkg::OFS_PRESCALE, 8'h03);
    wr(slcd_pkg::OFS_CONTROL, 8'h80);
    cyc(60);
    chk("type a", 24'(wave_type_b_o), 24'h000000);
    chk("step period", 24'(period), 24'h000004);
    chk("pin select", pin_drive_select_o, mask);
    chk("active", 24'(panel_active_o), 24'h000001);
    for (int l = 0; l < 4; l++)
      chk("line pixels", seen[24*l +: 24], {pv(3*l+9), pv(3*l+8), pv(3*l+7)} & mask);
    $display("t_drive done");
  endtask
  // sleep with sleep-stop clear and set, then off
  task automatic t_sleep();
    logic [1:0] line;
    logic [7:0] d;
    @(posedge clock_i);
    cpu_sleep_i <= 1'b1;
    cyc(10);
    chk("active in sleep", 24'(panel_active_o), 24'h000001);
    wr(slcd_pkg::OFS_CONTROL, 8'hc0);
    cyc(6);
    chk("halted", 24'(panel_active_o), 24'h000000);
    line = common_line_o;
    cyc(12);
    chk("line held", 24'(common_line_o), 24'(line));
    rd(slcd_pkg::OFS_STATUS, d);
    chk("status halted", 24'(d), 24'({4'h0, line, 2'b10}));
    @(posedge clock_i);
    cpu_sleep_i <= 1'b0;
    cyc(6);
    chk("resumed", 24'(panel_active_o), 24'h000001);
    wr(slcd_pkg::OFS_CONTROL, 8'h00);
    cyc(6);
    chk("off", 24'(panel_active_o), 24'h000000);
    chk("columns off", column_line_o, 24'h000000);
    $display("t_sleep done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_drive();
    t_sleep();
    final_report();
  end
  // watchdog
  initial begin
    #100us;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
